// [core/vlpd_decoder.sv]
// Line pixel decoder: fetches a line from display memory, emits blob colours
`timescale 1ns/100ps
`default_nettype none
module vlpd_decoder (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Line sequencing from raster timing
   input  wire logic        lineStart,
   input  wire logic [15:0] lineAddr,
   input  wire logic [3:0]  scanRow,
   output var  logic        busy,
   output var  logic        lineDone,
   output var  logic [3:0]  lineRepeat,
   // Display memory read port
   output var  logic        memRead,
   output var  logic [15:0] memAddr,
   input  wire logic [7:0]  memData,
   input  wire logic        memValid,
   // Character generator ROM
   output var  logic [7:0]  romCode,
   output var  logic [3:0]  romRow,
   input  wire logic [7:0]  romDots,
   // Blob colour stream to video adaptor
   output var  logic        pixValid,
   output var  logic [3:0]  pixColour,
   input  wire logic        pixReady
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_MODE, ST_CCTL, ST_HI, ST_LO, ST_ROM, ST_BLOB
   } vlpd_state_t;

   vlpd_state_t      state, next_state;
   vlpd_pkg::vlpd_mode_t mode, next_mode;
   logic [1:0]       res, next_res;
   logic [3:0]       next_lineRepeat;
   logic [15:0]      lineBase, next_lineBase;
   logic [15:0]      next_memAddr;
   logic             next_memRead;
   logic             next_busy;
   logic             next_lineDone;
   logic [3:0][3:0]  colourReg, next_colourReg;
   logic [7:0]       hiByte, next_hiByte;
   logic [7:0]       loByte, next_loByte;
   logic [7:0]       dots, next_dots;
   logic [7:0]       prevDots, next_prevDots;
   logic [7:0]       next_romCode;
   logic [3:0]       activeBg, next_activeBg;
   logic [6:0]       fieldIdx, next_fieldIdx;
   logic [2:0]       blobIdx, next_blobIdx;
   logic [3:0]       tickCnt, next_tickCnt;
   logic [3:0]       divSel;
   logic [6:0]       fieldsSel;
   logic [2:0]       bitPos;
   logic             hiBit, loBit, dotBit;
   logic             isChar;
   logic             pushBlob;
   logic             bufInReady;
   logic [3:0]       blobColour;

   // Blob clock and line length from the horizontal definition
   always_comb begin
      unique case (res)
         vlpd_pkg::RES_88: begin
            divSel    = vlpd_pkg::DIV_88;
            fieldsSel = vlpd_pkg::FIELDS_88;
         end
         vlpd_pkg::RES_176: begin
            divSel    = vlpd_pkg::DIV_176;
            fieldsSel = vlpd_pkg::FIELDS_176;
         end
         vlpd_pkg::RES_352: begin
            divSel    = vlpd_pkg::DIV_352; // [RULE12]
            fieldsSel = vlpd_pkg::FIELDS_352;
         end
         vlpd_pkg::RES_528: begin
            divSel    = vlpd_pkg::DIV_528;
            fieldsSel = vlpd_pkg::FIELDS_528; // [RULE12]
         end
      endcase
   end

   // Blob colour selection
   always_comb begin
      bitPos = vlpd_pkg::LAST_BLOB - blobIdx; // [RULE1] [RULE16]
      hiBit  = hiByte[bitPos];
      loBit  = loByte[bitPos];
      dotBit = dots[bitPos];
      isChar = (mode == vlpd_pkg::MODE_CHR4) || (mode == vlpd_pkg::MODE_CHR16);
      unique case (mode) // [RULE14]
         vlpd_pkg::MODE_GFX4:  blobColour = colourReg[{hiBit, loBit}]; // [RULE1] [RULE3]
         vlpd_pkg::MODE_CHR4:  blobColour = colourReg[{loBit, dotBit}]; // [RULE8] [RULE10]
         // Register set not consulted here
         vlpd_pkg::MODE_GFX16: blobColour = hiBit ? loByte[7:4] : activeBg; // [RULE5] [RULE6] [RULE7]
         vlpd_pkg::MODE_CHR16: blobColour = dotBit ? loByte[7:4] : loByte[3:0]; // [RULE8]
      endcase
   end

   // Line sequencer
   always_comb begin
      next_state      = state;
      next_mode       = mode;
      next_res        = res;
      next_lineRepeat = lineRepeat;
      next_lineBase   = lineBase;
      next_memAddr    = memAddr;
      next_memRead    = memRead;
      next_busy       = busy;
      next_lineDone   = 1'b0;
      next_colourReg  = colourReg;
      next_hiByte     = hiByte;
      next_loByte     = loByte;
      next_dots       = dots;
      next_prevDots   = prevDots;
      next_romCode    = romCode;
      next_activeBg   = activeBg;
      next_fieldIdx   = fieldIdx;
      next_blobIdx    = blobIdx;
      next_tickCnt    = tickCnt;
      pushBlob        = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (lineStart) begin
               next_lineBase = lineAddr;
               next_memAddr  = lineAddr;
               next_memRead  = 1'b1;
               next_busy     = 1'b1;
               next_state    = ST_MODE;
            end
         end
         ST_MODE: begin
            if (memValid) begin
               next_mode       = vlpd_pkg::vlpd_mode_t'(memData[vlpd_pkg::MODE_MSB:vlpd_pkg::MODE_LSB]); // [RULE14]
               next_res        = memData[vlpd_pkg::RES_MSB:vlpd_pkg::RES_LSB];
               next_lineRepeat = memData[vlpd_pkg::REP_MSB:vlpd_pkg::REP_LSB];
               next_memAddr    = memAddr - vlpd_pkg::ADDR_STEP;
               next_state      = ST_CCTL;
            end
         end
         ST_CCTL: begin
            if (memValid) begin
               if (memData[vlpd_pkg::CC_ENABLE]) begin
                  next_colourReg[memData[vlpd_pkg::CC_SEL_MSB:vlpd_pkg::CC_SEL_LSB]] =
                     memData[vlpd_pkg::CC_COL_MSB:vlpd_pkg::CC_COL_LSB]; // [RULE15]
               end
               next_memAddr  = memAddr - vlpd_pkg::ADDR_STEP;
               next_fieldIdx = '0;
               next_prevDots = vlpd_pkg::BYTE_RST;
               next_state    = ST_HI;
            end
         end
         ST_HI: begin
            if (memValid) begin
               next_hiByte  = memData;
               next_romCode = memData; // [RULE10]
               next_memAddr = memAddr - vlpd_pkg::ADDR_STEP; // [RULE13]
               next_state   = ST_LO;
            end
         end
         ST_LO: begin
            if (memValid) begin
               next_loByte  = memData; // [RULE4]
               next_memAddr = memAddr - vlpd_pkg::ADDR_STEP; // [RULE13]
               next_memRead = 1'b0;
               next_blobIdx = '0;
               next_tickCnt = '0;
               // First field of a line has no earlier background to carry
               if (fieldIdx == 7'h00) begin
                  next_activeBg = memData[3:0];
               end
               next_state = isChar ? ST_ROM : ST_BLOB;
            end
         end
         ST_ROM: begin
            // Glyph shown one position late; colour byte is not
            next_dots     = prevDots; // [RULE11]
            next_prevDots = romDots;
            next_state    = ST_BLOB;
         end
         ST_BLOB: begin
            if (tickCnt == divSel - 4'h1) begin
               // Receiver stall holds the blob; no colour is dropped
               if (bufInReady) begin
                  pushBlob     = 1'b1; // [RULE17]
                  next_tickCnt = '0;
                  if (mode == vlpd_pkg::MODE_GFX16 && hiBit) begin
                     next_activeBg = loByte[3:0]; // [RULE7]
                  end
                  if (blobIdx == vlpd_pkg::LAST_BLOB) begin // [RULE2]
                     if (fieldIdx == fieldsSel - 7'h01) begin // [RULE12]
                        next_busy     = 1'b0;
                        next_lineDone = 1'b1;
                        next_state    = ST_IDLE;
                     end else begin
                        next_fieldIdx = fieldIdx + 7'h01;
                        next_memRead  = 1'b1;
                        next_state    = ST_HI;
                     end
                  end else begin
                     next_blobIdx = blobIdx + 3'h1;
                  end
               end
            end else begin
               next_tickCnt = tickCnt + 4'h1;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state      <= ST_IDLE;
         mode       <= vlpd_pkg::MODE_GFX4;
         res        <= vlpd_pkg::RES_88;
         lineRepeat <= vlpd_pkg::COLOUR_RST;
         lineBase   <= vlpd_pkg::ADDR_RST;
         memAddr    <= vlpd_pkg::ADDR_RST;
         memRead    <= 1'b0;
         busy       <= 1'b0;
         lineDone   <= 1'b0;
         colourReg  <= '0;
         hiByte     <= vlpd_pkg::BYTE_RST;
         loByte     <= vlpd_pkg::BYTE_RST;
         dots       <= vlpd_pkg::BYTE_RST;
         prevDots   <= vlpd_pkg::BYTE_RST;
         romCode    <= vlpd_pkg::BYTE_RST;
         romRow     <= vlpd_pkg::COLOUR_RST;
         activeBg   <= vlpd_pkg::COLOUR_RST;
         fieldIdx   <= '0;
         blobIdx    <= '0;
         tickCnt    <= '0;
      end else begin
         state      <= next_state;
         mode       <= next_mode;
         res        <= next_res;
         lineRepeat <= next_lineRepeat;
         lineBase   <= next_lineBase;
         memAddr    <= next_memAddr;
         memRead    <= next_memRead;
         busy       <= next_busy;
         lineDone   <= next_lineDone;
         colourReg  <= next_colourReg;
         hiByte     <= next_hiByte;
         loByte     <= next_loByte;
         dots       <= next_dots;
         prevDots   <= next_prevDots;
         romCode    <= next_romCode;
         romRow     <= scanRow;
         activeBg   <= next_activeBg;
         fieldIdx   <= next_fieldIdx;
         blobIdx    <= next_blobIdx;
         tickCnt    <= next_tickCnt;
      end
   end

   vlpd_skid_buf #(
      .WIDTH(4)
   ) u_buf (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .inValid (pushBlob),
      .inData  (blobColour),
      .inReady (bufInReady),
      .outValid(pixValid),
      .outData (pixColour),
      .outReady(pixReady)
   );

   a_fourcol_pick: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE1] [RULE3]
      pushBlob && mode == vlpd_pkg::MODE_GFX4 |->
         blobColour == colourReg[{hiByte[3'h7 - blobIdx], loByte[3'h7 - blobIdx]}])
      else $error("four-colour blob not from colour register");

   a_eight_blobs: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE2]
      state == ST_BLOB && pushBlob && blobIdx != 3'h7 |=> state == ST_BLOB)
      else $error("field ended before eight blobs");

   a_field_end: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE2]
      state == ST_BLOB && pushBlob && blobIdx == 3'h7 |=> state != ST_BLOB)
      else $error("field ran past eight blobs");

   a_sixteen_fg: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE4] [RULE16]
      pushBlob && mode == vlpd_pkg::MODE_GFX16 && hiByte[3'h7 - blobIdx] |->
         blobColour == loByte[7:4])
      else $error("set bit did not give foreground");

   a_bg_carry: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE7]
      pushBlob && mode == vlpd_pkg::MODE_GFX16 && hiByte[3'h7 - blobIdx] |=>
         activeBg == $past(loByte[3:0]))
      else $error("background not updated after foreground use");

   a_regs_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE6] [RULE3]
      state != ST_CCTL |=> $stable(colourReg))
      else $error("colour registers changed outside colour control");

   a_colreg_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE15]
      state == ST_CCTL && memValid && memData[7] |=>
         colourReg[$past(memData[5:4])] == $past(memData[3:0]))
      else $error("colour control byte did not load register");

   a_char_delay: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE11]
      state == ST_ROM |=> dots == $past(prevDots) && prevDots == $past(romDots))
      else $error("glyph dots not delayed one position");

   a_char4_pick: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE10]
      pushBlob && mode == vlpd_pkg::MODE_CHR4 |->
         blobColour == colourReg[{loByte[3'h7 - blobIdx], dots[3'h7 - blobIdx]}])
      else $error("four-colour character index wrong");

   a_addr_stride: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
      state == ST_HI |-> memAddr == lineBase - 16'h0002 - {8'h00, fieldIdx, 1'b0})
      else $error("field byte address off stride");

   a_mode_latch: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE14]
      state == ST_MODE && memValid |=> mode == $past(memData[7:6]))
      else $error("mode bits not taken from mode byte");

   a_blob_rate: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
      pushBlob |-> tickCnt == divSel - 4'h1 ##1 !pushBlob)
      else $error("blob emitted off definition rate");

endmodule
`default_nettype wire

// [include/vlpd_pkg.sv]
// Constants and types shared by the line pixel decoder
// Overview of operation
// [RULE1] Four-colour code: hi and lo bits, MSB first
// [RULE2] Each field yields eight consecutive blobs
// [RULE3] Four-colour code indexes persistent colour registers
// [RULE4] Sixteen-colour: low byte nibbles give background, foreground
// [RULE5] Sixteen-colour: high byte bits pick fg or bg
// [RULE6] Sixteen-colour graphics ignores the colour registers
// [RULE7] Old background persists until new foreground used
// [RULE8] Character mode colours ROM dots per mode
// [RULE9] Memory should program repeat count at least eleven; the bench programs two for graphics lines
// [RULE10] Four-colour chars: dot and low byte form index
// [RULE11] Character dots delayed one position, colours not
// [RULE12] Characters per line follow horizontal definition
// [RULE13] Character and colour bytes descend by two
// [RULE14] Mode bits select one of four data modes
// [RULE15] Colour control byte updates one colour register
// [RULE16] High byte scanned MSB first, set means foreground
// [RULE17] One 4-bit colour per blob at definition rate
`default_nettype none
package vlpd_pkg;

   typedef enum logic [1:0] {
      MODE_GFX4  = 2'b00,
      MODE_CHR4  = 2'b01,
      MODE_GFX16 = 2'b10,
      MODE_CHR16 = 2'b11
   } vlpd_mode_t;

   // Mode byte field positions
   localparam int MODE_MSB   = 7;
   localparam int MODE_LSB   = 6;
   localparam int RES_MSB    = 5;
   localparam int RES_LSB    = 4;
   localparam int REP_MSB    = 3;
   localparam int REP_LSB    = 0;

   // Colour control byte field positions
   localparam int CC_ENABLE  = 7;
   localparam int CC_SEL_MSB = 5;
   localparam int CC_SEL_LSB = 4;
   localparam int CC_COL_MSB = 3;
   localparam int CC_COL_LSB = 0;

   // Resolution codes
   localparam logic [1:0] RES_88  = 2'h0;
   localparam logic [1:0] RES_176 = 2'h1;
   localparam logic [1:0] RES_352 = 2'h2;
   localparam logic [1:0] RES_528 = 2'h3;

   // Clocks per blob; inverse to 88:176:352:528, so the blobs of each line take 1056 clocks
   localparam logic [3:0] DIV_88  = 4'hC;
   localparam logic [3:0] DIV_176 = 4'h6;
   localparam logic [3:0] DIV_352 = 4'h3;
   localparam logic [3:0] DIV_528 = 4'h2;

   // Fields (characters) per line, definition divided by eight
   localparam logic [6:0] FIELDS_88  = 7'h0B;
   localparam logic [6:0] FIELDS_176 = 7'h16;
   localparam logic [6:0] FIELDS_352 = 7'h2C;
   localparam logic [6:0] FIELDS_528 = 7'h42;

   localparam logic [2:0]  LAST_BLOB   = 3'h7;
   localparam logic [15:0] ADDR_STEP   = 16'h0001;
   localparam logic [3:0]  COLOUR_RST  = 4'h0;
   localparam logic [7:0]  BYTE_RST    = 8'h00;
   localparam logic [15:0] ADDR_RST    = 16'h0000;

endpackage
`default_nettype wire

// [core/vlpd_skid_buf.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module vlpd_skid_buf #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output var  logic             inReady,
   // Drain side
   output var  logic             outValid,
   output var  logic [WIDTH-1:0] outData,
   input  wire logic             outReady
);

   logic [WIDTH-1:0] tail;
   logic             tailValid;
   logic [WIDTH-1:0] next_outData;
   logic [WIDTH-1:0] next_tail;
   logic             next_outValid;
   logic             next_tailValid;
   logic             push;
   logic             pop;

   // Ready comes from a flop so the source never sees a combinational loop
   assign inReady = !tailValid;

   always_comb begin
      push           = inValid && inReady;
      pop            = outValid && outReady;
      next_outData   = outData;
      next_tail      = tail;
      next_outValid  = outValid;
      next_tailValid = tailValid;
      if (pop) begin
         if (tailValid) begin
            next_outData   = tail;
            next_outValid  = 1'b1;
            next_tail      = inData;
            next_tailValid = push;
         end else begin
            next_outData  = inData;
            next_outValid = push;
         end
      end else if (push) begin
         if (!outValid) begin
            next_outData  = inData;
            next_outValid = 1'b1;
         end else begin
            next_tail      = inData;
            next_tailValid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         outData   <= '0;
         tail      <= '0;
         outValid  <= 1'b0;
         tailValid <= 1'b0;
      end else begin
         outData   <= next_outData;
         tail      <= next_tail;
         outValid  <= next_outValid;
         tailValid <= next_tailValid;
      end
   end

endmodule
`default_nettype wire

// [verif/vlpd_mem_model.sv]
// Display memory and glyph ROM facing the line decoder
`timescale 1ns/100ps
`default_nettype none
module vlpd_mem_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Answer speed
   input  wire logic        slow,
   // Memory read port
   input  wire logic        memRead,
   input  wire logic [15:0] memAddr,
   output var  logic [7:0]  memData,
   output var  logic        memValid,
   // Glyph ROM
   input  wire logic [7:0]  romCode,
   input  wire logic [3:0]  romRow,
   output var  logic [7:0]  romDots
);
   logic [7:0] mem [0:65535];
   logic [1:0] gap;

   // Idle gap after each answer, so the next answer sees the new address
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         memValid <= 1'b0;
         memData  <= 8'h5A;
         gap      <= 2'h0;
      end else if (memValid) begin
         memValid <= 1'b0;
         // Released bus shows garbage, never the old byte
         memData  <= ~memData;
         gap      <= slow ? 2'h3 : 2'h1;
      end else if (gap != 2'h0) begin
         gap <= gap - 2'h1;
      end else if (memRead) begin
         memValid <= 1'b1;
         memData  <= mem[memAddr];
      end
   end

   assign romDots = {romCode[3:0] ^ romRow, romCode[7:4]};
endmodule
`default_nettype wire

// [verif/test_video_line_pixel_decoder.sv]
// Self-checking bench for the line pixel decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin \
   checksDone++; \
   if ((got) !== (exp)) begin \
      badCount++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
   end \
end
module test_video_line_pixel_decoder;
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] res;
      logic [7:0] cc;
      logic [7:0] seed;
      logic       slow;
      logic       stall;
      logic       again;
   } vlpd_row_t;

   localparam logic [15:0] A = 16'hBFEF;
   localparam vlpd_row_t ROWS [7] = '{
      '{vlpd_pkg::MODE_GFX4,  2'h0, 8'h9A, 8'h3C, 1'b0, 1'b0, 1'b0},
      '{vlpd_pkg::MODE_GFX4,  2'h1, 8'h35, 8'hA5, 1'b1, 1'b1, 1'b0},
      '{vlpd_pkg::MODE_GFX16, 2'h0, 8'hBF, 8'h5E, 1'b0, 1'b1, 1'b1},
      '{vlpd_pkg::MODE_GFX16, 2'h2, 8'hA3, 8'hC1, 1'b1, 1'b0, 1'b0},
      '{vlpd_pkg::MODE_CHR4,  2'h0, 8'h8C, 8'h93, 1'b0, 1'b1, 1'b0},
      '{vlpd_pkg::MODE_CHR16, 2'h3, 8'hE6, 8'h2B, 1'b0, 1'b0, 1'b0},
      '{vlpd_pkg::MODE_CHR4,  2'h3, 8'hB1, 8'h6D, 1'b1, 1'b0, 1'b0}};

   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        lineStart = 1'b0;
   logic        pixReady = 1'b0;
   logic        slow = 1'b0;
   logic        stall = 1'b0;
   logic [15:0] lineAddr = 16'h0000;
   logic [3:0]  scanRow = 4'h0;
   logic        busy, lineDone, memRead, memValid, pixValid;
   logic [3:0]  lineRepeat, romRow, pixColour;
   logic [15:0] memAddr;
   logic [7:0]  memData, romCode, romDots;
   int          badCount = 0;
   int          checksDone = 0;
   int          doneCnt = 0;
   int          cyc = 0;
   logic [3:0]  creg [4];
   logic [3:0]  gotQ [$];
   logic [3:0]  expQ [$];

   vlpd_decoder dut (.clk_sys(clk_sys), .reset_n(reset_n), .lineStart(lineStart),
      .lineAddr(lineAddr), .scanRow(scanRow), .busy(busy), .lineDone(lineDone),
      .lineRepeat(lineRepeat), .memRead(memRead), .memAddr(memAddr), .memData(memData),
      .memValid(memValid), .romCode(romCode), .romRow(romRow), .romDots(romDots),
      .pixValid(pixValid), .pixColour(pixColour), .pixReady(pixReady));
   vlpd_mem_model mdl (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
      .memRead(memRead), .memAddr(memAddr), .memData(memData), .memValid(memValid),
      .romCode(romCode), .romRow(romRow), .romDots(romDots));

   always #50 clk_sys = ~clk_sys;

   // Stalling sink takes one word in eight clocks, so the buffer fills when a blob takes fewer than eight clocks (176 and up)
   always @(negedge clk_sys) begin
      cyc++;
      pixReady <= !stall || (cyc % 8 == 0);
   end

   always @(posedge clk_sys) begin
      if (pixValid === 1'b1 && pixReady === 1'b1)
         gotQ.push_back(pixColour);
      if (lineDone === 1'b1)
         doneCnt++;
   end

   function automatic logic [7:0] rom(input logic [7:0] c, input logic [3:0] r);
      return {c[3:0] ^ r, c[7:4]};
   endfunction

   task automatic fill(input vlpd_row_t r, output int nf);
      nf = (r.res == 2'h0) ? 11 : (r.res == 2'h1) ? 22 : (r.res == 2'h2) ? 44 : 66;
      mdl.mem[A] = {r.mode, r.res, r.mode[0] ? 4'hB : 4'h2};
      mdl.mem[A - 1] = r.cc;
      for (int k = 0; k < nf; k++) begin
         mdl.mem[A - 2 - 2 * k] = (k == 1) ? 8'h00 : r.seed ^ 8'(k * 37);
         mdl.mem[A - 3 - 2 * k] = r.seed + 8'(k * 13);
      end
   endtask

   // Reference decode of one line into expQ
   task automatic build(input int nf, input logic [3:0] row);
      logic [1:0] md;
      logic [7:0] cc, hi, lo, pd;
      logic [3:0] bg;
      logic [3:0] c;
      md = mdl.mem[A][7:6];
      cc = mdl.mem[A - 1];
      if (cc[7])
         creg[cc[5:4]] = cc[3:0];
      pd = 8'h00;
      expQ.delete();
      for (int k = 0; k < nf; k++) begin
         hi = mdl.mem[A - 2 - 2 * k];
         lo = mdl.mem[A - 3 - 2 * k];
         if (k == 0)
            bg = lo[3:0];
         for (int b = 7; b >= 0; b--) begin
            case (md)
               2'b00: c = creg[{hi[b], lo[b]}];
               2'b01: c = creg[{lo[b], pd[b]}];
               2'b10: begin
                  if (hi[b])
                     bg = lo[3:0];
                  c = hi[b] ? lo[7:4] : bg;
               end
               default: c = pd[b] ? lo[7:4] : lo[3:0];
            endcase
            expQ.push_back(c);
         end
         // Glyph dots show one position late
         pd = rom(hi, row);
      end
   endtask

   task automatic closeOut;
      $display("checks %0d, mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic runLine(input vlpd_row_t r);
      int nf;
      int n;
      int d0;
      slow = r.slow;
      stall = r.stall;
      scanRow = r.seed[3:0];
      fill(r, nf);
      build(nf, r.seed[3:0]);
      gotQ.delete();
      d0 = doneCnt;
      lineAddr = A;
      lineStart = 1'b1;
      @(negedge clk_sys);
      lineStart = 1'b0;
      if (r.again) begin
         repeat (30) @(negedge clk_sys);
         // Busy decoder must ignore this request to unfilled memory
         lineAddr = 16'h8000;
         lineStart = 1'b1;
         @(negedge clk_sys);
         lineStart = 1'b0;
      end
      n = 0;
      while ((doneCnt == d0 || gotQ.size() < expQ.size()) && n < 40000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 40000) begin
         badCount++;
         $display("unexpected hang: line never completed");
         closeOut();
      end
      repeat (4) @(negedge clk_sys);
      `CHK("blob count", expQ.size(), gotQ.size())
      `CHK("line done pulses", d0 + 1, doneCnt)
      `CHK("busy after line", 1'b0, busy)
      `CHK("repeat count", mdl.mem[A][3:0], lineRepeat)
      for (int i = 0; i < expQ.size() && i < gotQ.size(); i++)
         `CHK("blob colour", expQ[i], gotQ[i])
   endtask

   initial begin
      for (int i = 0; i < 4; i++)
         creg[i] = 4'h0;
      repeat (4) @(negedge clk_sys);
      `CHK("outputs in reset", 4'h0, {busy, memRead, pixValid, lineDone})
      reset_n = 1'b1;
      for (int i = 0; i < 7; i++)
         runLine(ROWS[i]);
      // Reset in mid-line clears the colour registers
      lineAddr = A;
      lineStart = 1'b1;
      @(negedge clk_sys);
      lineStart = 1'b0;
      repeat (40) @(negedge clk_sys);
      reset_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK("outputs in reset", 4'h0, {busy, memRead, pixValid, lineDone})
      reset_n = 1'b1;
      for (int i = 0; i < 4; i++)
         creg[i] = 4'h0;
      runLine('{vlpd_pkg::MODE_GFX4, 2'h0, 8'hC9, 8'h77, 1'b0, 1'b1, 1'b0});
      closeOut();
   end
endmodule
`undef CHK
`default_nettype wire
